// ==== rtl/result_unit_pkg.sv ====
// Constants, register map and carrier types of the sigma-delta result unit
package result_unit_pkg;

  localparam int NUM_CH   = 2;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int STRB_W   = DATA_W / 8;
  localparam int RAW_W    = 29;
  localparam int INT_W    = 32;
  localparam int RES_W    = 16;
  localparam int TS_W     = 9;
  localparam int CNT_W    = 3;
  localparam int SHIFT_W  = 4;
  localparam int HYST_W   = 4;
  localparam int THR_W    = 9;
  localparam int CMP_EW   = 11;

  // Window of the shifted internal word that forms the 16-bit result
  localparam int SLICE_LSB = 12;
  localparam int SLICE_MSB = SLICE_LSB + RES_W - 1;
  // Result bits taken into the comparators
  localparam int CMP_MSB  = 15;
  localparam int CMP_LSB  = 7;

  localparam logic [CNT_W-1:0] CNT_MAX = 3'h7;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CFG_A    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_B    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_EV_EN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EV_FLAG  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EV_CLR   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EV_SET   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PAIR     = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_STS_CLR  = 8'h4C;
  localparam logic [ADDR_W-1:0] OFS_STS      = 8'h50;
  localparam logic [ADDR_W-1:0] OFS_STS_SET  = 8'h54;
  localparam logic [NUM_CH-1:0][ADDR_W-1:0] OFS_CMP  = {8'h30, 8'h2C};
  localparam logic [NUM_CH-1:0][ADDR_W-1:0] OFS_RES  = {8'h38, 8'h34};
  localparam logic [NUM_CH-1:0][ADDR_W-1:0] OFS_CTIM = {8'h40, 8'h3C};

  // Writable bits and field positions of the configuration words
  localparam logic [DATA_W-1:0] CFG_A_MASK = 32'h000F_0707;
  localparam logic [DATA_W-1:0] CFG_B_MASK = 32'hF1FF_F1FF;
  localparam logic [DATA_W-1:0] CFG_RESET  = 32'h0000_0000;
  localparam int WFR_BIT0     = 2;
  localparam int WFR_STRIDE   = 8;
  localparam int SHIFT_LSB0   = 12;
  localparam int SHIFT_STRIDE = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_RANGE,
    MODE_OVER,
    MODE_UNDER,
    MODE_SPARE
  } cmp_mode_t;

  typedef enum logic [1:0] {
    COMB_OR,
    COMB_XOR,
    COMB_HIGH,
    COMB_LOW
  } comb_sel_t;

  typedef struct packed {
    logic [1:0]        spare;
    comb_sel_t         comb_sel;
    cmp_mode_t         mode;
    logic [HYST_W-1:0] low_hysteresis;
    logic [HYST_W-1:0] high_hysteresis;
    logic [THR_W-1:0]  lower;
    logic [THR_W-1:0]  upper;
  } comparator_control_t;

  typedef struct packed {
    logic              result_valid_flag;
    logic [2:0]        spare;
    logic [CNT_W-1:0]  discard_count;
    logic [TS_W-1:0]   timestamp_value;
    logic [RES_W-1:0]  result;
  } channel_result_t;

  typedef struct packed {
    logic              underflow;
    logic [TS_W-1:0]   dec_count;
    logic [RAW_W-1:0]  data;
  } cic_in_t;

endpackage : result_unit_pkg

// ==== rtl/sigma_delta_result_unit.sv ====
// Result generation, wait-for-read, timestamps and comparators of a two-channel filter
// Summary of operation
// - Event flag enable, read, set, separate clear
// - Event drives interrupt and DMA request
// - New result on every decimation underflow not discarded
// - Internal result: 29 raw bits plus 3
// - 16-bit result sliced by shift setting
// - Result is left aligned two's complement
// - Both results readable in one word
// - Wait-for-read discards result while still unread
// - Discard sets channel discard status flag
// - Each discard increments the discard counter, which holds at 7
// - Count 7 means overflow; update clears it
// - Valid set on update, cleared by read
// - Result carries 9-bit decimation timestamp
// - Trigger rising edge captures decimation counter
// - Signed 9-bit upper and lower thresholds
// - Compare result bits 15:7, ignore 6:0
// - Separate hysteresis for upper and lower
// - One high and one low output
// - Three compare modes per channel
// - Range mode: high above upper, low below lower
// - Combined output: OR, XOR, high, low
// - 4-bit shift fields at 15:12, 31:28
// - Wait-for-read enables at bits 2, 10
`timescale 1ns/1ns

module sigma_delta_result_unit (
  // Clock, reset, enable
  input  wire  logic                                   clk_sys,
  input  wire  logic                                   nrst,
  input  wire  logic                                   ce,
  // AXI4-Lite write channels
  input  wire  logic [result_unit_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire  logic                                   s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire  logic [result_unit_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire  logic [result_unit_pkg::STRB_W-1:0]     s_axi_wstrb,
  input  wire  logic                                   s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire  logic                                   s_axi_bready,
  // AXI4-Lite read channels
  input  wire  logic [result_unit_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire  logic                                   s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [result_unit_pkg::DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire  logic                                   s_axi_rready,
  // Filter side
  input  wire  result_unit_pkg::cic_in_t [result_unit_pkg::NUM_CH-1:0] cic_in,
  input  wire  logic [result_unit_pkg::NUM_CH-1:0]     timestamp_trigger,
  // Requests and compare outputs
  output logic [result_unit_pkg::NUM_CH-1:0]           event_irq,
  output logic [result_unit_pkg::NUM_CH-1:0]           event_dma_req,
  output logic [result_unit_pkg::NUM_CH-1:0]           high_compare_out,
  output logic [result_unit_pkg::NUM_CH-1:0]           low_compare_out,
  output logic [result_unit_pkg::NUM_CH-1:0]           combined_compare_out
);
  import result_unit_pkg::*;

  // Bus slave state
  logic                  aw_full;
  logic                  next_aw_full;
  logic [ADDR_W-1:0]     aw_addr;
  logic [ADDR_W-1:0]     next_aw_addr;
  logic                  w_full;
  logic                  next_w_full;
  logic [DATA_W-1:0]     w_data;
  logic [DATA_W-1:0]     next_w_data;
  logic [STRB_W-1:0]     w_strb;
  logic [STRB_W-1:0]     next_w_strb;
  logic                  next_awready;
  logic                  next_wready;
  logic                  next_arready;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_rvalid;
  logic [DATA_W-1:0]     next_rdata;
  logic [1:0]            next_rresp;

  // Software-visible state
  logic [DATA_W-1:0]     config_word_a;
  logic [DATA_W-1:0]     next_config_word_a;
  logic [DATA_W-1:0]     config_word_b;
  logic [DATA_W-1:0]     next_config_word_b;
  logic [NUM_CH-1:0]     event_enable_reg;
  logic [NUM_CH-1:0]     next_event_enable_reg;
  logic [NUM_CH-1:0]     event_flag_reg;
  logic [NUM_CH-1:0]     next_event_flag_reg;
  logic [NUM_CH-1:0]     status_reg;
  logic [NUM_CH-1:0]     next_status_reg;
  comparator_control_t   comparator_control      [NUM_CH];
  comparator_control_t   next_comparator_control [NUM_CH];

  // Per-channel views
  channel_result_t       channel_result_reg      [NUM_CH];
  logic [TS_W-1:0]       captured_timestamp_reg  [NUM_CH];
  logic [NUM_CH-1:0]     hw_event;
  logic [NUM_CH-1:0]     hw_discard;
  logic [NUM_CH-1:0]     read_clear;

  // Decode
  logic                  wr_go;
  logic                  rd_go;
  logic [ADDR_W-1:0]     wr_ofs;
  logic [ADDR_W-1:0]     rd_ofs;
  logic [DATA_W-1:0]     wr_mask;
  logic [DATA_W-1:0]     wr_bits;
  logic [DATA_W-1:0]     rd_data;
  logic                  rd_hit;
  logic                  wr_hit;

  function automatic logic mapped(input logic [ADDR_W-1:0] ofs);
    logic hit;
    hit = (ofs == OFS_CFG_A) || (ofs == OFS_CFG_B) || (ofs == OFS_EV_EN) ||
          (ofs == OFS_EV_FLAG) || (ofs == OFS_EV_CLR) || (ofs == OFS_EV_SET) ||
          (ofs == OFS_PAIR) || (ofs == OFS_STS_CLR) || (ofs == OFS_STS) ||
          (ofs == OFS_STS_SET);
    for (int c = 0; c < NUM_CH; c++) begin
      hit = hit || (ofs == OFS_CMP[c]) || (ofs == OFS_RES[c]) || (ofs == OFS_CTIM[c]);
    end
    return hit;
  endfunction : mapped

  assign wr_go  = aw_full && w_full;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign wr_ofs = {aw_addr[ADDR_W-1:2], 2'b00};
  assign rd_ofs = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign wr_hit = mapped(wr_ofs);
  assign rd_hit = mapped(rd_ofs);

  always_comb begin
    for (int b = 0; b < STRB_W; b++) begin
      wr_mask[b*8 +: 8] = {8{w_strb[b]}};
    end
    wr_bits = w_data & wr_mask;
  end

  // Write and read channel handshakes; write and address may arrive in either order
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      w_full        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      aw_full       <= next_aw_full;
      aw_addr       <= next_aw_addr;
      w_full        <= next_w_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Read data mux
  always_comb begin
    rd_data = '0;
    case (rd_ofs)
      OFS_CFG_A:   rd_data = config_word_a;
      OFS_CFG_B:   rd_data = config_word_b;
      OFS_EV_EN:   rd_data = DATA_W'(event_enable_reg);
      OFS_EV_FLAG: rd_data = DATA_W'(event_flag_reg);
      OFS_STS:     rd_data = DATA_W'(status_reg);
      OFS_PAIR:    rd_data = {channel_result_reg[1].result,
                              channel_result_reg[0].result};
      default: begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (rd_ofs == OFS_CMP[c]) begin
            rd_data = comparator_control[c];
          end
          if (rd_ofs == OFS_RES[c]) begin
            rd_data = channel_result_reg[c];
          end
          if (rd_ofs == OFS_CTIM[c]) begin
            rd_data = DATA_W'(captured_timestamp_reg[c]);
          end
        end
      end
    endcase
  end

  // A read of a result word, or of the pair, clears the valid flag at the handshake
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      read_clear[c] = rd_go && ((rd_ofs == OFS_RES[c]) || (rd_ofs == OFS_PAIR));
    end
  end

  // Configuration, enables, event and discard flags; hardware set wins over clear
  always_comb begin
    next_config_word_a    = config_word_a;
    next_config_word_b    = config_word_b;
    next_event_enable_reg = event_enable_reg;
    next_comparator_control = comparator_control;
    next_event_flag_reg   = event_flag_reg;
    next_status_reg       = status_reg;
    if (wr_go) begin
      if (wr_ofs == OFS_CFG_A) begin
        next_config_word_a = ((config_word_a & ~wr_mask) | wr_bits) & CFG_A_MASK;
      end
      if (wr_ofs == OFS_CFG_B) begin
        next_config_word_b = ((config_word_b & ~wr_mask) | wr_bits) & CFG_B_MASK;
      end
      if (wr_ofs == OFS_EV_EN) begin
        next_event_enable_reg = (event_enable_reg & ~wr_mask[NUM_CH-1:0]) |
                                wr_bits[NUM_CH-1:0];
      end
      if (wr_ofs == OFS_EV_CLR) begin
        next_event_flag_reg = event_flag_reg & ~wr_bits[NUM_CH-1:0];
      end
      if ((wr_ofs == OFS_EV_FLAG) || (wr_ofs == OFS_EV_SET)) begin
        next_event_flag_reg = event_flag_reg | wr_bits[NUM_CH-1:0];
      end
      if (wr_ofs == OFS_STS_CLR) begin
        next_status_reg = status_reg & ~wr_bits[NUM_CH-1:0];
      end
      if (wr_ofs == OFS_STS_SET) begin
        next_status_reg = status_reg | wr_bits[NUM_CH-1:0];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (wr_ofs == OFS_CMP[c]) begin
          next_comparator_control[c] = (comparator_control[c] & ~wr_mask) | wr_bits;
        end
      end
    end
    next_event_flag_reg = next_event_flag_reg | hw_event;
    next_status_reg     = next_status_reg | hw_discard;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      config_word_a    <= CFG_RESET;
      config_word_b    <= CFG_RESET;
      event_enable_reg <= '0;
      event_flag_reg   <= '0;
      status_reg       <= '0;
      event_irq        <= '0;
      event_dma_req    <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        comparator_control[c] <= '0;
      end
    end else if (ce) begin
      config_word_a      <= next_config_word_a;
      config_word_b      <= next_config_word_b;
      event_enable_reg   <= next_event_enable_reg;
      event_flag_reg     <= next_event_flag_reg;
      status_reg         <= next_status_reg;
      event_irq          <= event_flag_reg & event_enable_reg;
      event_dma_req      <= event_flag_reg & event_enable_reg;
      comparator_control <= next_comparator_control;
    end
  end

  // Per-channel result path, timestamp capture and comparator
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    channel_result_t             res_q;
    channel_result_t             next_res;
    logic [TS_W-1:0]             ctim_q;
    logic [TS_W-1:0]             next_ctim;
    logic [2:0]                  trg_sync;
    logic                        trg_level;
    logic                        next_trg_level;
    logic                        hi_q;
    logic                        next_hi;
    logic                        lo_q;
    logic                        next_lo;
    logic                        comb_q;
    logic                        next_comb;
    logic                        wfr_en;
    logic [SHIFT_W-1:0]          shift;
    logic [INT_W-1:0]            internal;
    logic [INT_W-1:0]            shifted;
    logic                        discard;
    logic                        update;
    logic signed [CMP_EW-1:0]    val;
    logic signed [CMP_EW-1:0]    thr_hi;
    logic signed [CMP_EW-1:0]    thr_lo;
    logic signed [CMP_EW-1:0]    hys_hi;
    logic signed [CMP_EW-1:0]    hys_lo;
    comparator_control_t         ctl;

    assign wfr_en = config_word_a[WFR_BIT0 + i*WFR_STRIDE];
    assign shift  = config_word_b[SHIFT_LSB0 + i*SHIFT_STRIDE +: SHIFT_W];
    assign ctl    = comparator_control[i];

    always_comb begin
      // Sign-extend the raw word and pick the result window
      internal = {{(INT_W-RAW_W){cic_in[i].data[RAW_W-1]}}, cic_in[i].data};
      shifted  = internal << shift;
      discard  = cic_in[i].underflow && wfr_en && res_q.result_valid_flag;
      update   = cic_in[i].underflow && !discard;
      next_res = res_q;
      if (update) begin
        next_res.result            = shifted[SLICE_MSB:SLICE_LSB];
        next_res.timestamp_value   = cic_in[i].dec_count;
        next_res.discard_count     = '0;
        next_res.result_valid_flag = 1'b1;
      end else begin
        if (discard && (res_q.discard_count != CNT_MAX)) begin
          next_res.discard_count = res_q.discard_count + 1'b1;
        end
        if (read_clear[i]) begin
          next_res.result_valid_flag = 1'b0;
        end
      end
      // Timestamp trigger: counted once the last two sync stages agree
      next_trg_level = trg_level;
      next_ctim      = ctim_q;
      if (trg_sync[1] == trg_sync[2]) begin
        next_trg_level = trg_sync[2];
        if (trg_sync[2] && !trg_level) begin
          next_ctim = cic_in[i].dec_count;
        end
      end
      // Signed compare of result bits 15:7 in a widened range
      val    = CMP_EW'(signed'(res_q.result[CMP_MSB:CMP_LSB]));
      thr_hi = CMP_EW'(signed'(ctl.upper));
      thr_lo = CMP_EW'(signed'(ctl.lower));
      hys_hi = signed'(CMP_EW'(ctl.high_hysteresis));
      hys_lo = signed'(CMP_EW'(ctl.low_hysteresis));
      unique case (ctl.mode)
        MODE_OVER: begin
          next_hi = hi_q ? (val > thr_hi - hys_hi) : (val > thr_hi);
          next_lo = lo_q ? (val > thr_lo - hys_lo) : (val > thr_lo);
        end
        MODE_UNDER: begin
          next_hi = hi_q ? (val < thr_hi + hys_hi) : (val < thr_hi);
          next_lo = lo_q ? (val < thr_lo + hys_lo) : (val < thr_lo);
        end
        default: begin
          // Range mode; the spare code behaves the same
          next_hi = hi_q ? (val > thr_hi - hys_hi) : (val > thr_hi);
          next_lo = lo_q ? (val < thr_lo + hys_lo) : (val < thr_lo);
        end
      endcase
      unique case (ctl.comb_sel)
        COMB_OR:   next_comb = next_hi | next_lo;
        COMB_XOR:  next_comb = next_hi ^ next_lo;
        COMB_HIGH: next_comb = next_hi;
        COMB_LOW:  next_comb = next_lo;
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (!nrst) begin
        res_q     <= '0;
        ctim_q    <= '0;
        trg_sync  <= '0;
        trg_level <= 1'b0;
        hi_q      <= 1'b0;
        lo_q      <= 1'b0;
        comb_q    <= 1'b0;
      end else if (ce) begin
        res_q     <= next_res;
        ctim_q    <= next_ctim;
        trg_sync  <= {trg_sync[1:0], timestamp_trigger[i]};
        trg_level <= next_trg_level;
        hi_q      <= next_hi;
        lo_q      <= next_lo;
        comb_q    <= next_comb;
      end
    end

    assign channel_result_reg[i]     = res_q;
    assign captured_timestamp_reg[i] = ctim_q;
    assign hw_event[i]               = cic_in[i].underflow;
    assign hw_discard[i]             = discard;
    assign high_compare_out[i]       = hi_q;
    assign low_compare_out[i]        = lo_q;
    assign combined_compare_out[i]   = comb_q;
  end

endmodule : sigma_delta_result_unit

// ==== verification/result_unit_props.sv ====
// Bus timing, request pairing and reset checks on the result unit ports
`timescale 1ns/1ns
module result_unit_props (
  // Clock, reset, enable
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        ce,
  // Register bus
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // Requests
  input wire logic [1:0]  event_irq, event_dma_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst || !ce);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response timing");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
  a_irq_dma_pair: assert property (event_irq == event_dma_req)
    else $error("request lines differ");
  a_reset_idle: assert property ($rose(nrst)
    |-> !s_axi_arready && !s_axi_awready && event_irq == 2'b00) else $error("busy after reset");
endmodule : result_unit_props
bind sigma_delta_result_unit result_unit_props u_props (.*);

// ==== verification/cic_model.sv ====
// Filter-side model: live decimation counter and one-cycle result strobes
`timescale 1ns/1ns
module cic_model (
  input wire logic                          clk_sys,
  input wire logic                          nrst,
  input wire logic [1:0]                    fire,
  input wire logic [28:0]                   data,
  output result_unit_pkg::cic_in_t [1:0]    cic_in
);
  import result_unit_pkg::*;
  logic [8:0] cnt, next_cnt;
  always_comb begin
    next_cnt = nrst ? cnt - 9'h001 : 9'h1FF;
    // Data is not held outside the strobe, so show its inverse there
    // Strobes carry settled results only, so the bench skips none
    for (int c = 0; c < 2; c++) begin
      cic_in[c] = '{underflow: fire[c], dec_count: cnt, data: fire[c] ? data : ~data};
    end
  end
  always_ff @(posedge clk_sys) cnt <= next_cnt;
endmodule : cic_model

// ==== verification/sigma_delta_result_unit_tb.sv ====
// Register-level testbench of the sigma-delta result unit
`timescale 1ns/1ns
module sigma_delta_result_unit_tb;
  import result_unit_pkg::*;
  logic clk_sys, nrst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, timestamp_trigger, event_irq, event_dma_req, fire, r;
  logic [1:0]  high_compare_out, low_compare_out, combined_compare_out;
  logic [5:0]  cmp_out;
  logic [28:0] data;
  logic [8:0]  ts, t0;
  cic_in_t [1:0] cic_in;
  int failures = 0, samples_checked = 0, cyc = 0;
  sigma_delta_result_unit dut (.*);
  cic_model far_side (.*);
  assign cmp_out = {high_compare_out, low_compare_out, combined_compare_out};
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  task conclude;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude;
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(ad && dd)) begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 0; end
      if (!dd && s_axi_wready) begin dd = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk_sys);
  endtask : rd
  task fire_ch(input int c, input logic [28:0] v);
    data <= v;
    fire[c] <= 1'b1;
    @(posedge clk_sys);
    ts = cic_in[c].dec_count;
    fire <= 2'b00;
    @(posedge clk_sys);
  endtask : fire_ch
  initial begin
    nrst = 0; ce = 1; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0;
    s_axi_rready = 0; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF;
    timestamp_trigger = 0; fire = 0; data = 0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1;
    @(posedge clk_sys);
    wr(8'h04, 32'hF000_4000);
    fire_ch(0, 29'h001_2345);
    t0 = ts;
    fire_ch(1, 29'h1FFF_FFFF);
    rd(8'h34); chk("result0", {1'b1, 6'h00, t0, 16'h0123}, d);
    rd(8'h38); chk("result1", {1'b1, 6'h00, ts, 16'hFFF8}, d);
    rd(8'h48); chk("pair", 32'hFFF8_0123, d);
    rd(8'h34); chk("read clears valid", {1'b0, 6'h00, t0, 16'h0123}, d);
    chk("compare", 6'h1B, cmp_out);
    $display("test result path done");
    wr(8'h10, 32'h0000_0003);
    @(posedge clk_sys);
    chk("irq", 2'b11, event_irq);
    chk("dma", 2'b11, event_dma_req);
    wr(8'h18, 32'h0000_0001); rd(8'h14); chk("flag clear", 2'b10, d);
    wr(8'h14, 32'h0000_0001); rd(8'h14); chk("flag set", 2'b11, d);
    $display("test events done");
    wr(8'h00, 32'h0000_0004);
    fire_ch(0, 29'h000_0100);
    t0 = ts;
    repeat (8) fire_ch(0, 29'h0FFF_FFFF);
    rd(8'h34); chk("discard", {1'b1, 6'h07, t0, 16'h0001}, d);
    rd(8'h50); chk("status", 32'h0000_0001, d);
    fire_ch(0, 29'h000_0200);
    rd(8'h34); chk("update", {1'b1, 6'h00, ts, 16'h0002}, d);
    rd(8'h08);
    chk("unmapped resp", RESP_SLVERR, r);
    chk("unmapped data", 32'h0000_0000, d);
    $display("test wait for read done");
    wr(8'h2C, 32'h1800_0201);
    chk("under xor", 6'h1E, cmp_out);
    timestamp_trigger <= 2'b01;
    repeat (4) @(posedge clk_sys);
    t0 = cic_in[0].dec_count;
    rd(8'h3C);
    chk("capture", {23'h00_0000, t0}, d);
    $display("test compare and capture done");
    conclude;
  end
endmodule : sigma_delta_result_unit_tb
